/* clock_select_common.sv */
// Constants shared by the system clock source selector, plus the pin edge synchroniser.
// Assumes one 250 MHz clock; every slower rate is an enable pulse derived from it.

// ==========================================
// Package
// ==========================================
package clock_select_pkg;

    // Register map and bus widths
    localparam int          ADDR_W          = 4;
    localparam int          DATA_W          = 8;
    localparam logic [3:0]  OSC_CTRL_ADDR   = 4'h0;
    localparam logic [3:0]  OSC_STAT_ADDR   = 4'h1;
    localparam logic [3:0]  OSC_CFG_ADDR    = 4'h2;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;

    // Control field positions
    localparam int          CTRL_SEL_LSB    = 0;
    localparam int          CTRL_PLL_EN     = 2;
    localparam int          CTRL_SLOW_SEL   = 3;
    localparam int          CTRL_CLKOUT_EN  = 4;
    localparam int          CTRL_PERIPH_EN  = 5;

    // Status field positions
    localparam int          STAT_EXT_RDY    = 0;
    localparam int          STAT_SOSC_RDY   = 1;
    localparam int          STAT_FAST_RDY   = 2;
    localparam int          STAT_SLOW_RDY   = 3;
    localparam int          STAT_PLL_RDY    = 4;
    localparam int          STAT_SRC_LSB    = 5;

    // Start-up configuration codes
    localparam logic [2:0]  CFG_EXT_LOW     = 3'h0;
    localparam logic [2:0]  CFG_EXT_MED     = 3'h1;
    localparam logic [2:0]  CFG_EXT_HIGH    = 3'h2;
    localparam logic [2:0]  CFG_RES_LOW     = 3'h3;
    localparam logic [2:0]  CFG_RES_MID     = 3'h4;
    localparam logic [2:0]  CFG_RES_HIGH    = 3'h5;
    localparam logic [2:0]  CFG_EXT_RC      = 3'h6;
    localparam logic [2:0]  CFG_INT_FAST    = 3'h7;

    // Run clock select values
    localparam logic [1:0]  SEL_CONFIG      = 2'h0;
    localparam logic [1:0]  SEL_SECONDARY   = 2'h1;

    // Active source codes; external is zero so reset lands on it
    localparam logic [2:0]  SRC_EXT         = 3'h0;
    localparam logic [2:0]  SRC_SOSC        = 3'h1;
    localparam logic [2:0]  SRC_FAST        = 3'h2;
    localparam logic [2:0]  SRC_PLL         = 3'h3;
    localparam logic [2:0]  SRC_SLOW        = 3'h4;

    // Amplifier gain codes
    localparam logic [1:0]  GAIN_OFF        = 2'h0;
    localparam logic [1:0]  GAIN_LOW        = 2'h1;
    localparam logic [1:0]  GAIN_MID        = 2'h2;
    localparam logic [1:0]  GAIN_HIGH       = 2'h3;

    // Rates and derived cycle counts
    localparam longint      CLK_HZ          = 250_000_000;
    localparam longint      FAST_HZ         = 16_000_000;
    localparam longint      SLOW_HZ         = 31_000;
    localparam longint      PERIPH_HZ       = 600_000;
    localparam longint      PLL_HZ          = 32_000_000;
    localparam logic [3:0]  FAST_DIV        = 4'(CLK_HZ / FAST_HZ);
    localparam int          SLOW_DIV        = int'(CLK_HZ / SLOW_HZ);
    localparam logic [8:0]  PERIPH_DIV      = 9'(CLK_HZ / PERIPH_HZ);
    localparam logic [2:0]  PLL_DIV         = 3'(CLK_HZ / PLL_HZ);
    localparam logic [7:0]  PLL_LOCK_CYC    = 8'h40;
    localparam logic [10:0] OST_COUNT       = 11'h400;
    localparam logic [4:0]  SOSC_WARM       = 5'h10;
    localparam logic [1:0]  SYNC_WARM       = 2'h3;

endpackage

`timescale 1ns/10ps
`default_nettype none

// ==========================================
// Pin edge synchroniser
// ==========================================
module pin_edge_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // Pin and edge
    input  wire logic pin,
    output logic      rise
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic rise;
        logic [1:0] warm;
    } sync_t;

    sync_t st_r;
    sync_t st_nxt;

    always_comb begin
        st_nxt      = st_r;
        st_nxt.s1   = pin;
        st_nxt.s2   = st_r.s1;
        st_nxt.s3   = st_r.s2;
        st_nxt.warm = (st_r.warm == clock_select_pkg::SYNC_WARM) ?
                      st_r.warm : st_r.warm + 2'h1;
        // Held off until the last stage holds a real sample; a pin left high
        // at reset release would otherwise show a false rise
        st_nxt.rise = st_r.s2 & ~st_r.s3 & (st_r.warm == clock_select_pkg::SYNC_WARM);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rise = st_r.rise;

endmodule // pin_edge_sync

`default_nettype wire

/* clock_select_props.sv */
// Port-level checks on the system clock source selector.
// Assumes startup_osc_cfg holds still between resets.
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Checker
// ==========================================
module clock_select_props #(
    parameter int SLOW_DIV = 20
) (
    // Clock and reset
    input wire logic       clk,
    input wire logic       resetn,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // Configuration and outputs
    input wire logic [2:0] startup_osc_cfg,
    input wire logic       osc_out_pin_oe,
    input wire logic       periph_clk_en,
    input wire logic [1:0] amp_gain
);
    logic [1:0] cnt_r;
    // Cfg-derived outputs settle only a few edges after release
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= 2'h0;
        end else if (cnt_r != 2'h3) begin
            cnt_r <= cnt_r + 2'h1;
        end
    end
    wire logic       ec_mode  = (startup_osc_cfg < 3'h3) || (startup_osc_cfg == 3'h6);
    wire logic       res_mode = (startup_osc_cfg > 3'h2) && (startup_osc_cfg < 3'h6);
    wire logic [1:0] gain_exp = res_mode ? 2'(startup_osc_cfg - 3'h2) : 2'h0;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_rd(logic [3:0] a);
        reg_rd && reg_addr == a && cnt_r == 2'h3;
    endsequence
    property p_cfg_rb;
        s_rd(4'h2) |=> reg_rdata == {5'h00, startup_osc_cfg};
    endproperty
    property p_unmapped;
        reg_rd && reg_addr > 4'h2 |=> reg_rdata == 8'h00;
    endproperty
    property p_idle;
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    property p_int_rdy;
        s_rd(4'h1) |=> reg_rdata[3:2] == 2'h3;
    endproperty
    property p_ext_rdy;
        s_rd(4'h1) and ec_mode |=> reg_rdata[0];
    endproperty
    property p_pll;
        s_rd(4'h1) |=> reg_rdata[4] == (reg_rdata[7:5] == 3'h3);
    endproperty
    property p_gain;
        cnt_r == 2'h3 && startup_osc_cfg != 3'h7 |-> amp_gain == gain_exp;
    endproperty
    property p_res_oe;
        cnt_r == 2'h3 && res_mode |-> !osc_out_pin_oe;
    endproperty
    property p_periph;
        periph_clk_en |=> !periph_clk_en [*8];
    endproperty
    a_cfg_rb: assert property (p_cfg_rb) else $error("cfg readback wrong");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_idle: assert property (p_idle) else $error("read data outside read slot");
    a_int_rdy: assert property (p_int_rdy) else $error("internal ready low");
    a_ext_rdy: assert property (p_ext_rdy) else $error("logic clock not ready");
    a_pll: assert property (p_pll) else $error("pll flag off source");
    a_gain: assert property (p_gain) else $error("amplifier gain wrong");
    a_res_oe: assert property (p_res_oe) else $error("pin two driven in resonator");
    a_periph: assert property (p_periph) else $error("peripheral pulse too soon");
endmodule // clock_select_props
bind system_clock_source_select clock_select_props #(.SLOW_DIV(SLOW_DIV)) clock_select_props_inst (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .startup_osc_cfg(startup_osc_cfg),
    .osc_out_pin_oe(osc_out_pin_oe), .periph_clk_en(periph_clk_en), .amp_gain(amp_gain));
`default_nettype wire

/* osc_partner_model.sv */
// Far side: logic clock or resonator on pin one, secondary crystal.
// Assumes the bench sets run; a resonator swings only with gain on.
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Oscillator model
// ==========================================
module osc_partner_model (
    // Control
    input  wire logic       run,
    input  wire logic       logic_src,
    input  wire logic [1:0] amp_gain,
    // Pins
    output logic            osc_in_pin,
    output logic            sosc_in_pin
);
    initial begin
        osc_in_pin = 1'b0;
        #1.3;
        forever begin
            #32;
            // Stopped clock holds its level, as a halted source would
            if (run && (logic_src || amp_gain != 2'h0)) osc_in_pin = ~osc_in_pin;
        end
    end
    initial begin
        sosc_in_pin = 1'b0;
        forever #61.7 sosc_in_pin = ~sosc_in_pin;
    end
endmodule // osc_partner_model
`default_nettype wire

/* system_clock_source_select.sv */
// System clock source selector: start-up default, run-time switch, ready status.
// Assumes clk at 250 MHz, oscillator pins asynchronous, register port on clk.

`timescale 1ns/10ps
`default_nettype none

module system_clock_source_select #(
    parameter int SLOW_DIV = clock_select_pkg::SLOW_DIV
) (
    // Clock and reset
    input  wire logic                                clk,
    input  wire logic                                resetn,
    // Register port
    input  wire logic [clock_select_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [clock_select_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                                reg_wr,
    input  wire logic                                reg_rd,
    output logic      [clock_select_pkg::DATA_W-1:0] reg_rdata,
    // Start-up configuration and core state
    input  wire logic [2:0]                          startup_osc_cfg,
    input  wire logic                                sleep_req,
    // Oscillator pins
    input  wire logic                                osc_in_pin,
    input  wire logic                                sosc_in_pin,
    output logic                                     osc_out_pin_o,
    output logic                                     osc_out_pin_oe,
    // Port logic sharing the second pin
    input  wire logic                                gpio_out_val,
    input  wire logic                                gpio_out_drive,
    // Clock enables and analog controls
    output logic                                     sys_clk_en,
    output logic                                     periph_clk_en,
    output logic      [1:0]                          amp_gain
);

    // ==========================================
    // State
    // ==========================================
    typedef struct packed {
        logic        cfg_taken;
        logic [2:0]  cfg_mode;
        logic [1:0]  run_clock_select;
        logic        pll_enable;
        logic        slow_sel;
        logic        clkout_en;
        logic        periph_en;
        logic [7:0]  rdata;
        logic [10:0] ost_cnt;
        logic        ost_done;
        logic [4:0]  sosc_cnt;
        logic        sosc_ready;
        logic [3:0]  fast_cnt;
        logic        fast_pulse;
        logic [13:0] slow_cnt;
        logic        slow_pulse;
        logic [7:0]  lock_cnt;
        logic        pll_locked;
        logic [2:0]  pll_cnt;
        logic        pll_pulse;
        logic [8:0]  per_cnt;
        logic        per_pulse;
        logic [2:0]  active;
        logic        pll_ready_flag;
        logic        sys_en;
        logic        clkout_lvl;
        logic        pin2_o;
        logic        pin2_oe;
        logic [1:0]  gain;
    } state_t;

    localparam logic [13:0] SLOW_LAST = 14'(SLOW_DIV - 1);

    state_t st_r;
    state_t st_nxt;

    logic ext_rise;
    logic sosc_rise;

    // ==========================================
    // Pin synchronisers
    // ==========================================
    pin_edge_sync u_ext_sync (
        .clk    (clk),
        .resetn (resetn),
        .pin    (osc_in_pin),
        .rise   (ext_rise)
    );

    pin_edge_sync u_sosc_sync (
        .clk    (clk),
        .resetn (resetn),
        .pin    (sosc_in_pin),
        .rise   (sosc_rise)
    );

    // ==========================================
    // Helpers
    // ==========================================
    function automatic logic is_resonator(input logic [2:0] mode);
        is_resonator = (mode == clock_select_pkg::CFG_RES_LOW) ||
                       (mode == clock_select_pkg::CFG_RES_MID) ||
                       (mode == clock_select_pkg::CFG_RES_HIGH);
    endfunction

    function automatic logic is_logic_clock(input logic [2:0] mode);
        is_logic_clock = (mode == clock_select_pkg::CFG_EXT_LOW) ||
                         (mode == clock_select_pkg::CFG_EXT_MED) ||
                         (mode == clock_select_pkg::CFG_EXT_HIGH);
    endfunction

    // Combinational views of the current state
    logic       ext_ready;
    logic       src_ready_tgt;
    logic       src_ready_old;
    logic       old_pulse;
    logic [2:0] cfg_src;
    logic [2:0] target;

    always_comb begin
        // Resonators wait for the timer; logic clocks and RC need no settling
        // Internal fast start-up has no external source, so never wait on the pin
        ext_ready = is_resonator(st_r.cfg_mode) ? st_r.ost_done :
                    (st_r.cfg_taken && (st_r.cfg_mode != clock_select_pkg::CFG_INT_FAST));
        cfg_src   = (st_r.cfg_mode == clock_select_pkg::CFG_INT_FAST) ?
                    clock_select_pkg::SRC_FAST : clock_select_pkg::SRC_EXT;
        if (st_r.run_clock_select == clock_select_pkg::SEL_CONFIG) begin
            target = cfg_src;
        end else if (st_r.run_clock_select == clock_select_pkg::SEL_SECONDARY) begin
            target = clock_select_pkg::SRC_SOSC;
        end else if (st_r.slow_sel) begin
            target = clock_select_pkg::SRC_SLOW;
        end else if (st_r.pll_enable) begin
            target = clock_select_pkg::SRC_PLL;
        end else begin
            target = clock_select_pkg::SRC_FAST;
        end
    end

    // Ready and pulse of a given source
    function automatic logic ready_of(input logic [2:0] src, input state_t s,
                                      input logic ext_rdy);
        unique case (src)
            clock_select_pkg::SRC_EXT:  ready_of = ext_rdy;
            clock_select_pkg::SRC_SOSC: ready_of = s.sosc_ready;
            clock_select_pkg::SRC_PLL:  ready_of = s.pll_locked;
            default:                    ready_of = s.cfg_taken;
        endcase
    endfunction

    function automatic logic pulse_of(input logic [2:0] src, input state_t s,
                                      input logic ext_p, input logic sosc_p);
        unique case (src)
            clock_select_pkg::SRC_EXT:  pulse_of = ext_p;
            clock_select_pkg::SRC_SOSC: pulse_of = sosc_p;
            clock_select_pkg::SRC_FAST: pulse_of = s.fast_pulse;
            clock_select_pkg::SRC_PLL:  pulse_of = s.pll_pulse;
            default:                    pulse_of = s.slow_pulse;
        endcase
    endfunction

    always_comb begin
        src_ready_tgt = ready_of(target, st_r, ext_ready);
        src_ready_old = ready_of(st_r.active, st_r, ext_ready);
        old_pulse     = pulse_of(st_r.active, st_r, ext_rise, sosc_rise);
    end

    // ==========================================
    // Next state
    // ==========================================
    always_comb begin
        st_nxt = st_r;

        // Start-up configuration caught once, the cycle after reset release
        if (!st_r.cfg_taken) begin
            st_nxt.cfg_taken = 1'b1;
            st_nxt.cfg_mode  = startup_osc_cfg;
        end

        // Register writes
        if (reg_wr && (reg_addr == clock_select_pkg::OSC_CTRL_ADDR)) begin
            st_nxt.run_clock_select = reg_wdata[clock_select_pkg::CTRL_SEL_LSB +: 2];
            st_nxt.pll_enable       = reg_wdata[clock_select_pkg::CTRL_PLL_EN];
            st_nxt.slow_sel         = reg_wdata[clock_select_pkg::CTRL_SLOW_SEL];
            st_nxt.clkout_en        = reg_wdata[clock_select_pkg::CTRL_CLKOUT_EN];
            st_nxt.periph_en        = reg_wdata[clock_select_pkg::CTRL_PERIPH_EN];
        end

        // Register reads, data in the following cycle; unmapped reads zero
        st_nxt.rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                clock_select_pkg::OSC_CTRL_ADDR: begin
                    st_nxt.rdata = {2'b00, st_r.periph_en, st_r.clkout_en, st_r.slow_sel,
                                    st_r.pll_enable, st_r.run_clock_select};
                end
                clock_select_pkg::OSC_STAT_ADDR: begin
                    // Ready bits let software confirm a switch before sleep
                    st_nxt.rdata = {st_r.active, st_r.pll_ready_flag, st_r.cfg_taken,
                                    st_r.cfg_taken, st_r.sosc_ready, ext_ready};
                end
                clock_select_pkg::OSC_CFG_ADDR: begin
                    st_nxt.rdata = {5'h00, st_r.cfg_mode};
                end
                default: begin
                    st_nxt.rdata = 8'h00;
                end
            endcase
        end

        // Start-up timer: restarts on sleep or while the internal block is selected
        if (!is_resonator(st_r.cfg_mode) || sleep_req || st_r.run_clock_select[1]) begin
            st_nxt.ost_cnt  = 11'h000;
            st_nxt.ost_done = 1'b0;
        end else if (ext_rise && !st_r.ost_done) begin
            if (st_r.ost_cnt == clock_select_pkg::OST_COUNT - 11'h001) begin
                st_nxt.ost_done = 1'b1;
            end else begin
                st_nxt.ost_cnt = st_r.ost_cnt + 11'h001;
            end
        end

        // Secondary oscillator warm-up by edge count
        if (sosc_rise && !st_r.sosc_ready) begin
            if (st_r.sosc_cnt == clock_select_pkg::SOSC_WARM - 5'h01) begin
                st_nxt.sosc_ready = 1'b1;
            end else begin
                st_nxt.sosc_cnt = st_r.sosc_cnt + 5'h01;
            end
        end

        // Internal fast and slow oscillators as enable dividers
        st_nxt.fast_pulse = 1'b0;
        if (st_r.fast_cnt == clock_select_pkg::FAST_DIV - 4'h1) begin
            st_nxt.fast_cnt   = 4'h0;
            st_nxt.fast_pulse = 1'b1;
        end else begin
            st_nxt.fast_cnt = st_r.fast_cnt + 4'h1;
        end

        st_nxt.slow_pulse = 1'b0;
        if (st_r.slow_cnt == SLOW_LAST) begin
            st_nxt.slow_cnt   = 14'h0000;
            st_nxt.slow_pulse = 1'b1;
        end else begin
            st_nxt.slow_cnt = st_r.slow_cnt + 14'h0001;
        end

        // PLL: lock delay after enable, then an enable pulse every 7 cycles, about 35.7 MHz
        st_nxt.pll_pulse = 1'b0;
        if (!st_r.pll_enable) begin
            st_nxt.lock_cnt   = 8'h00;
            st_nxt.pll_locked = 1'b0;
            st_nxt.pll_cnt    = 3'h0;
        end else if (!st_r.pll_locked) begin
            if (st_r.lock_cnt == clock_select_pkg::PLL_LOCK_CYC - 8'h01) begin
                st_nxt.pll_locked = 1'b1;
            end else begin
                st_nxt.lock_cnt = st_r.lock_cnt + 8'h01;
            end
        end else if (st_r.pll_cnt == clock_select_pkg::PLL_DIV - 3'h1) begin
            st_nxt.pll_cnt   = 3'h0;
            st_nxt.pll_pulse = 1'b1;
        end else begin
            st_nxt.pll_cnt = st_r.pll_cnt + 3'h1;
        end

        // Peripheral RC clock, free of the system selection
        st_nxt.per_pulse = 1'b0;
        if (!st_r.periph_en) begin
            st_nxt.per_cnt = 9'h000;
        end else if (st_r.per_cnt == clock_select_pkg::PERIPH_DIV - 9'h001) begin
            st_nxt.per_cnt   = 9'h000;
            st_nxt.per_pulse = 1'b1;
        end else begin
            st_nxt.per_cnt = st_r.per_cnt + 9'h001;
        end

        // Switch only on a boundary of the old source, or at once if it is dead,
        // so the enable train never shows a runt period
        if ((target != st_r.active) && src_ready_tgt &&
            (old_pulse || !src_ready_old)) begin
            st_nxt.active = target;
        end
        st_nxt.pll_ready_flag = (st_nxt.active == clock_select_pkg::SRC_PLL);

        // System enable follows source edges only, so a stopped clock freezes sys_clk_en; periph_clk_en keeps running
        st_nxt.sys_en = old_pulse && !sleep_req && src_ready_old;

        // Second pin: clock out or port data in logic and RC modes, idle for crystals
        if (st_nxt.sys_en) begin
            st_nxt.clkout_lvl = ~st_r.clkout_lvl;
        end
        if (is_resonator(st_r.cfg_mode)) begin
            st_nxt.pin2_o  = 1'b0;
            st_nxt.pin2_oe = 1'b0;
        end else if (st_r.clkout_en) begin
            st_nxt.pin2_o  = st_r.clkout_lvl;
            st_nxt.pin2_oe = 1'b1;
        end else begin
            st_nxt.pin2_o  = gpio_out_val;
            st_nxt.pin2_oe = gpio_out_drive;
        end

        // Amplifier gain; logic clock classes only differ in input power
        unique case (st_r.cfg_mode)
            clock_select_pkg::CFG_RES_LOW:  st_nxt.gain = clock_select_pkg::GAIN_LOW;
            clock_select_pkg::CFG_RES_MID:  st_nxt.gain = clock_select_pkg::GAIN_MID;
            clock_select_pkg::CFG_RES_HIGH: st_nxt.gain = clock_select_pkg::GAIN_HIGH;
            default:                        st_nxt.gain = clock_select_pkg::GAIN_OFF;
        endcase
        if (is_logic_clock(st_r.cfg_mode)) begin
            st_nxt.gain = clock_select_pkg::GAIN_OFF;
        end
    end

    // ==========================================
    // Registers
    // ==========================================
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================
    // Outputs
    // ==========================================
    assign reg_rdata      = st_r.rdata;
    assign osc_out_pin_o  = st_r.pin2_o;
    assign osc_out_pin_oe = st_r.pin2_oe;
    assign sys_clk_en     = st_r.sys_en;
    assign periph_clk_en  = st_r.per_pulse;
    assign amp_gain       = st_r.gain;

endmodule // system_clock_source_select

`default_nettype wire

/* tb.sv */
// Self-checking bench for the clock source selector.
// Assumes the oscillator model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Bench
// ==========================================
module tb;
    logic       clk, resetn, reg_wr, reg_rd, sleep_req, run, logic_src;
    logic       gpio_out_val, gpio_out_drive, osc_in_pin, sosc_in_pin;
    logic       osc_out_pin_o, osc_out_pin_oe, sys_clk_en, periph_clk_en;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d;
    logic [2:0] startup_osc_cfg;
    logic [1:0] amp_gain;
    int         error_cnt = 0;
    int         checked = 0;
    int         ns, np;
    time        t0;
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    system_clock_source_select #(.SLOW_DIV(20)) system_clock_source_select_inst (
        .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .startup_osc_cfg(startup_osc_cfg), .sleep_req(sleep_req),
        .osc_in_pin(osc_in_pin), .sosc_in_pin(sosc_in_pin), .osc_out_pin_o(osc_out_pin_o),
        .osc_out_pin_oe(osc_out_pin_oe), .gpio_out_val(gpio_out_val),
        .gpio_out_drive(gpio_out_drive), .sys_clk_en(sys_clk_en),
        .periph_clk_en(periph_clk_en), .amp_gain(amp_gain));
    osc_partner_model osc_partner_model_inst (.run(run), .logic_src(logic_src),
        .amp_gain(amp_gain), .osc_in_pin(osc_in_pin), .sosc_in_pin(sosc_in_pin));
    task automatic test_done();
        if (error_cnt == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    // Status moves on source pulses, or at once when the old source is dead, so poll under a bound
    task automatic poll(input logic [7:0] m, input logic [7:0] e);
        logic [7:0] v;
        for (int i = 0; i < 12000 && (v & m) !== e; i++) rd(4'h1, v);
        chk(v & m, e);
        if ((v & m) !== e) test_done();
    endtask
    task automatic count(input int n);
        ns = 0;
        np = 0;
        repeat (n) begin
            @(posedge clk);
            #1;
            ns += sys_clk_en;
            np += periph_clk_en;
        end
    endtask
    task automatic boot(input logic [2:0] c);
        resetn <= 1'b0;
        startup_osc_cfg <= c;
        logic_src <= c < 3'h3 || c == 3'h6;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
    function automatic logic [7:0] gain_of(input logic [2:0] c);
        return (c > 3'h2 && c < 3'h6) ? 8'(c - 3'h2) : 8'h00;
    endfunction
    initial begin
        {resetn, reg_wr, reg_rd, sleep_req, gpio_out_val, gpio_out_drive} = '0;
        {reg_addr, reg_wdata, startup_osc_cfg} = '0;
        run = 1'b1;
        logic_src = 1'b1;
        void'($urandom(63));
        for (int c = 0; c < 8; c++) begin
            boot(3'(c));
            rd(4'h2, d);
            chk(d, 8'(c));
            rd(4'h1, d);
            chk(d & 8'h0c, 8'h0c);
            chk(d & 8'he0, (c == 7) ? 8'h40 : 8'h00);
            if (c != 7) chk({6'h00, amp_gain}, gain_of(3'(c)));
            if (c > 2 && c < 6) chk({7'h00, osc_out_pin_oe}, 8'h00);
            rd(4'(3 + $urandom_range(12)), d);
            chk(d, 8'h00);
        end
        boot(3'h5);
        t0 = $time;
        poll(8'h01, 8'h01);
        chk(8'($time - t0 > 65000), 8'h01);
        boot(3'h0);
        count(64);
        chk(8'(ns > 2), 8'h01);
        run <= 1'b0;
        count(20);
        count(100);
        chk(8'(ns), 8'h00);
        run <= 1'b1;
        count(64);
        chk(8'(ns > 2), 8'h01);
        sleep_req <= 1'b1;
        count(4);
        count(64);
        chk(8'(ns), 8'h00);
        sleep_req <= 1'b0;
        repeat (6) begin
            @(posedge clk);
            {gpio_out_val, gpio_out_drive} <= 2'($urandom);
            @(posedge clk);
            #1 chk({6'h00, osc_out_pin_oe, osc_out_pin_o}, {6'h00, gpio_out_drive, gpio_out_val});
        end
        wr(4'h0, 8'h10);
        count(40);
        chk({7'h00, osc_out_pin_oe}, 8'h01);
        wr(4'h0, 8'h20);
        count(10);
        count(832);
        chk(8'(np), 8'h02);
        wr(4'h0, 8'h02);
        poll(8'hf0, 8'h40);
        wr(4'h0, 8'h06);
        poll(8'hf0, 8'h70);
        wr(4'h0, 8'h02);
        poll(8'hf0, 8'h40);
        wr(4'h0, 8'h01);
        poll(8'hf2, 8'h22);
        wr(4'h0, 8'h0a);
        poll(8'hf0, 8'h80);
        wr(4'h0, 8'h00);
        poll(8'hf0, 8'h00);
        test_done();
    end
endmodule // tb
`default_nettype wire
